// >>> hdl/multifunction_terminal_router.sv
// multifunction terminal router: pulse counter on inputs, routed contact outputs
// assumes a plain register port and internal status from the core clock domain
//
// Notes on behaviour
// - input select code 74 makes that terminal the pulse counter source
// - every captured pulse adds one to a readable running total
// - total is volatile and returns to zero on reset
// - while a terminal coded 75 is on, the total is cleared
// - highest countable rate is 250/(response time+1) Hz; faster is missed
// - each collector output and the relay have their own function select
// - each output may be normally open or normally closed independently
// - polarity 00 is normally open, 01 closed; relay pairs are complementary
// - fault mode 01 puts a 3-bit fault code on outputs one to three
// - fault mode 02 puts a 4-bit fault code on outputs one to four
// - codes 00 to 13 select the first fourteen status signals in order
// - codes 19 to 32, except 30, select brake, speed, analog loss and link signals
// - codes 33 to 38 select the six logic results
// - codes 39 to 43 select life, contact, overheat and low current signals
// - codes 44 to 49 select six user program outputs
// - codes 50 to 56 select ready, direction, fatal fault and comparators
`timescale 1ns/100ps
`default_nettype none
module multifunction_terminal_router
    import mft_pkg::*;
#(
    parameter int TICK_CYCLES = FILTER_TICK_CYCLES,
    parameter int COUNT_W = 32
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [NUM_INPUTS-1:0] terminal_in,
    input wire logic [STATUS_W-1:0] internal_status,
    input wire logic [ALARM_W-1:0] alarm_code,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic [NUM_COLLECTORS-1:0] collector_out,
    output logic [NUM_COLLECTORS-1:0] collector_oe,
    output logic relay_first_closed,
    output logic relay_second_closed,
    output logic [COUNT_W-1:0] pulse_total_monitor,
    output logic irq
);
    if (TICK_CYCLES < 1 || COUNT_W < 1 || COUNT_W > DATA_W) begin : bad_params
        $error("unsupported TICK_CYCLES or COUNT_W");
    end

    // configuration registers
    logic [SEL_W-1:0] input_terminal_function_select [NUM_INPUTS];
    logic [SEL_W-1:0] input_response_time_setting [NUM_INPUTS];
    logic [SEL_W-1:0] collector_output_function_select [NUM_COLLECTORS];
    logic [SEL_W-1:0] collector_output_polarity [NUM_COLLECTORS];
    logic [SEL_W-1:0] relay_output_function_select;
    logic [SEL_W-1:0] relay_output_polarity;
    logic [SEL_W-1:0] fault_code_output_mode;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    logic [COUNT_W-1:0] pulse_total;
    logic [31:0] tick_cnt;
    logic tick;
    logic pulse_prev;
    logic clear_prev;
    logic [NUM_INPUTS-1:0] level;
    logic [NUM_INPUTS-1:0] count_mask;
    logic [NUM_INPUTS-1:0] clear_mask;
    logic pulse_count_input;
    logic pulse_total_clear;
    logic pulse_rise;
    logic [IRQ_W-1:0] events;
    logic [DATA_W-1:0] next_rdata;
    logic [NUM_COLLECTORS-1:0] next_collector;
    logic next_relay;

    term_filter_if #(.N(NUM_INPUTS), .W(SEL_W)) filt_bus();

    term_filter #(.N(NUM_INPUTS), .W(SEL_W)) u_filter (
        .core_clk(core_clk),
        .srst(srst),
        .bus(filt_bus)
    );

    assign filt_bus.raw = terminal_in;
    assign filt_bus.tick = tick;
    assign filt_bus.setting = input_response_time_setting;
    assign level = filt_bus.level;

    // output code decode shared by all six outputs
    function automatic logic code_listed(input logic [SEL_W-1:0] code);
        code_listed = (code <= CODE_LOW_LAST)
            || (code >= CODE_HIGH_FIRST && code <= CODE_HIGH_LAST && code != CODE_GAP)
            || (code == CODE_OPTION);
    endfunction

    function automatic logic route(input logic [SEL_W-1:0] code,
                                   input logic [STATUS_W-1:0] st);
        route = code_listed(code) ? st[code[5:0]] : 1'b0;
    endfunction

    // filter time base
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // terminal function decode
    always_comb begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
            count_mask[i] = input_terminal_function_select[i] == FN_PULSE_COUNT;
            clear_mask[i] = input_terminal_function_select[i] == FN_PULSE_CLEAR;
        end
        pulse_count_input = |(level & count_mask);
        pulse_total_clear = |(level & clear_mask);
        pulse_rise = pulse_count_input & ~pulse_prev;
    end

    // pulse total
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pulse_total <= '0;
            pulse_prev <= 1'b0;
            clear_prev <= 1'b0;
        end else begin
            pulse_prev <= pulse_count_input;
            clear_prev <= pulse_total_clear;
            if (pulse_total_clear) begin
                pulse_total <= '0;
            end else if (pulse_rise) begin
                pulse_total <= pulse_total + COUNT_W'(1);
            end
        end
    end

    // interrupt events
    always_comb begin
        events = '0;
        events[IRQ_COUNT] = pulse_rise & ~pulse_total_clear;
        events[IRQ_CLEAR] = pulse_total_clear & ~clear_prev;
        events[IRQ_WRAP] = events[IRQ_COUNT] & (&pulse_total);
    end

    // register writes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                input_terminal_function_select[i] <= RST_IN_SEL;
                input_response_time_setting[i] <= RST_RESP;
            end
            for (int i = 0; i < NUM_COLLECTORS; i++) begin
                collector_output_function_select[i] <= RST_COL_SEL;
                collector_output_polarity[i] <= RST_COL_POL;
            end
            relay_output_function_select <= RST_RLY_SEL;
            relay_output_polarity <= RST_RLY_POL;
            fault_code_output_mode <= RST_FAULT_MODE;
            irq_mask <= '0;
        end else if (reg_wr) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                if (reg_addr == A_IN_SEL_BASE + 8'(i)) begin
                    input_terminal_function_select[i] <= reg_wdata[SEL_W-1:0];
                end
                if (reg_addr == A_RESP_BASE + 8'(i)) begin
                    input_response_time_setting[i] <= reg_wdata[SEL_W-1:0];
                end
            end
            for (int i = 0; i < NUM_COLLECTORS; i++) begin
                if (reg_addr == A_COL_SEL_BASE + 8'(i)) begin
                    collector_output_function_select[i] <= reg_wdata[SEL_W-1:0];
                end
                if (reg_addr == A_COL_POL_BASE + 8'(i)) begin
                    collector_output_polarity[i] <= reg_wdata[SEL_W-1:0];
                end
            end
            if (reg_addr == A_RLY_SEL) begin
                relay_output_function_select <= reg_wdata[SEL_W-1:0];
            end
            if (reg_addr == A_RLY_POL) begin
                relay_output_polarity <= reg_wdata[SEL_W-1:0];
            end
            if (reg_addr == A_FAULT_MODE) begin
                fault_code_output_mode <= reg_wdata[SEL_W-1:0];
            end
            if (reg_addr == A_IRQ_MASK) begin
                irq_mask <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_status <= '0;
        end else if (reg_wr && reg_addr == A_IRQ_STATUS) begin
            irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // register reads
    always_comb begin
        next_rdata = '0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (reg_addr == A_IN_SEL_BASE + 8'(i)) begin
                next_rdata[SEL_W-1:0] = input_terminal_function_select[i];
            end
            if (reg_addr == A_RESP_BASE + 8'(i)) begin
                next_rdata[SEL_W-1:0] = input_response_time_setting[i];
            end
        end
        for (int i = 0; i < NUM_COLLECTORS; i++) begin
            if (reg_addr == A_COL_SEL_BASE + 8'(i)) begin
                next_rdata[SEL_W-1:0] = collector_output_function_select[i];
            end
            if (reg_addr == A_COL_POL_BASE + 8'(i)) begin
                next_rdata[SEL_W-1:0] = collector_output_polarity[i];
            end
        end
        if (reg_addr == A_RLY_SEL) begin
            next_rdata[SEL_W-1:0] = relay_output_function_select;
        end
        if (reg_addr == A_RLY_POL) begin
            next_rdata[SEL_W-1:0] = relay_output_polarity;
        end
        if (reg_addr == A_FAULT_MODE) begin
            next_rdata[SEL_W-1:0] = fault_code_output_mode;
        end
        if (reg_addr == A_PULSE_TOTAL) begin
            next_rdata[COUNT_W-1:0] = pulse_total;
        end
        if (reg_addr == A_IRQ_STATUS) begin
            next_rdata[IRQ_W-1:0] = irq_status;
        end
        if (reg_addr == A_IRQ_MASK) begin
            next_rdata[IRQ_W-1:0] = irq_mask;
        end
        if (reg_addr == A_TERM_LEVEL) begin
            next_rdata[NUM_INPUTS-1:0] = level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // output routing, fault code override, contact polarity
    always_comb begin
        for (int i = 0; i < NUM_COLLECTORS; i++) begin
            next_collector[i] = route(collector_output_function_select[i],
                                      internal_status);
            if (fault_code_output_mode == MODE_3BIT && i < 3) begin
                next_collector[i] = alarm_code[i];
            end
            if (fault_code_output_mode == MODE_4BIT && i < 4) begin
                next_collector[i] = alarm_code[i];
            end
            next_collector[i] = next_collector[i]
                ^ collector_output_polarity[i][POL_BIT];
        end
        next_relay = route(relay_output_function_select, internal_status)
            ^ relay_output_polarity[POL_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            collector_out <= '0;
            collector_oe <= '0;
            relay_first_closed <= 1'b0;
            relay_second_closed <= 1'b1;
        end else begin
            collector_out <= '0;
            collector_oe <= next_collector;
            relay_first_closed <= next_relay;
            relay_second_closed <= ~next_relay;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pulse_total_monitor <= '0;
            irq <= 1'b0;
        end else begin
            pulse_total_monitor <= pulse_total;
            irq <= |(irq_status & irq_mask);
        end
    end

    chk_reset_zero: assert property (@(posedge core_clk) disable iff (srst)
        $fell(srst) |-> pulse_total == '0)
        else $error("pulse total not zero after reset");

    chk_clear_wins: assert property (@(posedge core_clk) disable iff (srst)
        pulse_total_clear |=> pulse_total == '0)
        else $error("clear did not zero the pulse total");

    chk_count_step: assert property (@(posedge core_clk) disable iff (srst)
        (pulse_rise && !pulse_total_clear) |=> pulse_total == $past(pulse_total) + COUNT_W'(1))
        else $error("pulse total did not step by one");

    chk_no_source: assert property (@(posedge core_clk) disable iff (srst)
        (count_mask == '0 && !pulse_total_clear) |=> pulse_total == $past(pulse_total))
        else $error("pulse total moved with no counting terminal");

    chk_monitor_follow: assert property (@(posedge core_clk) disable iff (srst)
        ##1 pulse_total_monitor == $past(pulse_total))
        else $error("monitor value does not follow pulse total");

    chk_relay_pairs: assert property (@(posedge core_clk) disable iff (srst)
        relay_first_closed != relay_second_closed)
        else $error("relay contact pairs not complementary");

    chk_relay_route: assert property (@(posedge core_clk) disable iff (srst)
        (relay_output_function_select == 8'h00) |=> relay_first_closed
            == ($past(internal_status[0]) ^ $past(relay_output_polarity[POL_BIT])))
        else $error("relay does not follow the run signal");

    chk_alarm_three: assert property (@(posedge core_clk) disable iff (srst)
        (fault_code_output_mode == MODE_3BIT) |=> collector_oe[2:0]
            == ($past(alarm_code[2:0]) ^ $past({collector_output_polarity[2][POL_BIT],
            collector_output_polarity[1][POL_BIT], collector_output_polarity[0][POL_BIT]})))
        else $error("fault code not on outputs one to three");

    chk_unlisted_idle: assert property (@(posedge core_clk) disable iff (srst)
        !code_listed(collector_output_function_select[4])
            |=> collector_oe[4] == $past(collector_output_polarity[4][POL_BIT]))
        else $error("unallocated output not at inactive level");

    chk_irq_level: assert property (@(posedge core_clk) disable iff (srst)
        ##1 irq == $past(|(irq_status & irq_mask)))
        else $error("interrupt output disagrees with masked status");
endmodule
`default_nettype wire

// >>> hdl/term_filter.sv
// input terminal synchroniser and response-time filter
// assumes raw pins are asynchronous and tick is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module term_filter
    import mft_pkg::*;
#(
    parameter int N = 8,
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    term_filter_if.filt bus
);
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;
    logic [N-1:0] agreed;
    logic [N-1:0] level;
    logic [W-1:0] cnt [N];

    if (N < 1 || W < 1) begin : bad_params
        $error("unsupported N or W");
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            agreed <= '0;
        end else begin
            sync1 <= bus.raw;
            sync2 <= sync1;
            sync3 <= sync2;
            agreed <= (sync2 & sync3) | (agreed & (sync2 ^ sync3));
        end
    end

    // a change is taken after setting+1 ticks of stability
    always_ff @(posedge core_clk) begin
        if (srst) begin
            level <= '0;
            for (int i = 0; i < N; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (agreed[i] == level[i]) begin
                    cnt[i] <= '0;
                end else if (bus.tick) begin
                    if (cnt[i] == bus.setting[i]) begin
                        level[i] <= agreed[i];
                        cnt[i] <= '0;
                    end else begin
                        cnt[i] <= cnt[i] + W'(1);
                    end
                end
            end
        end
    end

    assign bus.level = level;

    chk_level_on_tick: assert property (@(posedge core_clk) disable iff (srst)
        (level != $past(level)) |-> $past(bus.tick))
        else $error("terminal level changed without a filter tick");
endmodule
`default_nettype wire

// >>> pkg/mft_pkg.sv
// constants shared by the terminal router and its input filter
// assumes one 50 MHz core clock and word-indexed register addresses
package mft_pkg;

    // clock and input-filter timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RATE_LIMIT_HZ = 250;
    localparam int RECOMMENDED_MAX_HZ = 100;
    localparam int FILTER_TICK_NS = 1_000_000_000 / (2 * RATE_LIMIT_HZ);
    localparam int FILTER_TICK_CYCLES = FILTER_TICK_NS / CLK_PERIOD_NS;

    // sizes
    localparam int NUM_INPUTS = 8;
    localparam int NUM_COLLECTORS = 5;
    localparam int SEL_W = 8;
    localparam int STATUS_W = 64;
    localparam int ALARM_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // input function codes
    localparam logic [7:0] FN_PULSE_COUNT = 8'h4A;
    localparam logic [7:0] FN_PULSE_CLEAR = 8'h4B;
    localparam logic [7:0] FN_NO_ALLOC = 8'hFF;

    // output code map boundaries
    localparam logic [7:0] CODE_LOW_LAST = 8'h0D;
    localparam logic [7:0] CODE_HIGH_FIRST = 8'h13;
    localparam logic [7:0] CODE_GAP = 8'h1E;
    localparam logic [7:0] CODE_HIGH_LAST = 8'h38;
    localparam logic [7:0] CODE_OPTION = 8'h3F;

    // fault code output modes and contact polarity
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] MODE_3BIT = 8'h01;
    localparam logic [7:0] MODE_4BIT = 8'h02;
    localparam logic [7:0] POL_NO = 8'h00;
    localparam logic [7:0] POL_NC = 8'h01;
    localparam int POL_BIT = 0;

    // register offsets
    localparam logic [7:0] A_IN_SEL_BASE = 8'h00;
    localparam logic [7:0] A_RESP_BASE = 8'h08;
    localparam logic [7:0] A_COL_SEL_BASE = 8'h10;
    localparam logic [7:0] A_RLY_SEL = 8'h15;
    localparam logic [7:0] A_COL_POL_BASE = 8'h18;
    localparam logic [7:0] A_RLY_POL = 8'h1D;
    localparam logic [7:0] A_FAULT_MODE = 8'h1E;
    localparam logic [7:0] A_PULSE_TOTAL = 8'h20;
    localparam logic [7:0] A_IRQ_STATUS = 8'h21;
    localparam logic [7:0] A_IRQ_MASK = 8'h22;
    localparam logic [7:0] A_TERM_LEVEL = 8'h23;

    // reset values
    localparam logic [7:0] RST_IN_SEL = 8'hFF;
    localparam logic [7:0] RST_RESP = 8'h00;
    localparam logic [7:0] RST_COL_SEL = 8'hFF;
    localparam logic [7:0] RST_RLY_SEL = 8'h05;
    localparam logic [7:0] RST_COL_POL = 8'h00;
    localparam logic [7:0] RST_RLY_POL = 8'h01;
    localparam logic [7:0] RST_FAULT_MODE = 8'h00;

    // interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_COUNT = 0;
    localparam int IRQ_CLEAR = 1;
    localparam int IRQ_WRAP = 2;

endpackage

// >>> pkg/term_filter_if.sv
// signals between the router and its input terminal filter
// assumes both ends run on the same core clock
`timescale 1ns/100ps
`default_nettype none
interface term_filter_if #(
    parameter int N = 8,
    parameter int W = 8
);
    logic [N-1:0] raw;
    logic tick;
    logic [W-1:0] setting [N];
    logic [N-1:0] level;

    modport ctrl(output raw, output tick, output setting, input level);
    modport filt(input raw, input tick, input setting, output level);
endinterface
`default_nettype wire

// >>> verification/multifunction_terminal_router_tb.sv
// self-checking bench for the terminal router
// assumes a shortened filter tick of 4 cycles and the partner terminal model
`timescale 1ns/100ps
`default_nettype none
module multifunction_terminal_router_tb
    import mft_pkg::*;
;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [NUM_INPUTS-1:0] terminal_in;
    logic [STATUS_W-1:0] internal_status = '0;
    logic [ALARM_W-1:0] alarm_code = '0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_COLLECTORS-1:0] collector_out;
    logic [NUM_COLLECTORS-1:0] collector_oe;
    logic relay_first_closed;
    logic relay_second_closed;
    logic [31:0] pulse_total_monitor;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 77;
    logic [31:0] rv;
    logic [7:0] sel [6];
    logic [7:0] pol [6];
    logic [7:0] mode;
    logic exp_r;
    int pidx;
    int cidx;

    initial forever #10 core_clk = ~core_clk;

    multifunction_terminal_router #(.TICK_CYCLES(4), .COUNT_W(32)) multifunction_terminal_router_inst (
        .core_clk(core_clk), .srst(srst), .terminal_in(terminal_in),
        .internal_status(internal_status), .alarm_code(alarm_code), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .collector_out(collector_out), .collector_oe(collector_oe),
        .relay_first_closed(relay_first_closed), .relay_second_closed(relay_second_closed),
        .pulse_total_monitor(pulse_total_monitor), .irq(irq)
    );

    terminal_driver terminal_driver_inst (.core_clk(core_clk), .terminal_in(terminal_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic route(input logic [7:0] c, input logic [63:0] st);
        if (c <= 8'h0D || (c >= 8'h13 && c <= 8'h38 && c != 8'h1E) || c == 8'h3F)
            return st[c[5:0]];
        return 1'b0;
    endfunction

    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        wait_cyc(3);
        chk(collector_oe, 32'h0);
        chk(relay_first_closed, 32'h1);
        chk(relay_second_closed, 32'h0);
        for (int a = 0; a < 32; a++) begin
            rd(8'(a), rv);
            if (a < 8 || (a >= 16 && a < 21)) chk(rv, 32'hFF);
            else if (a == 21 || a == 29) chk(rv, {31'h0, a == 29} | {24'h0, 8'(a == 21) * 8'h05});
            else chk(rv, 32'h0);
        end
        rd(8'h40, rv);
        chk(rv, 32'h0);
        // random routing, polarity and fault-code override
        for (int k = 0; k < 30; k++) begin
            internal_status <= {$random(seed), $random(seed)};
            alarm_code <= 4'($random(seed));
            mode = 8'(k % 3);
            for (int i = 0; i < 6; i++) begin
                sel[i] = (k % 8 == 7) ? 8'hFF : 8'($unsigned($random(seed)) % 64);
                pol[i] = 8'($random(seed) & 1);
                wr(8'h10 + 8'(i), {24'h0, sel[i]});
                wr(8'h18 + 8'(i), {24'h0, pol[i]});
            end
            wr(8'h1E, {24'h0, mode});
            wait_cyc(3);
            for (int i = 0; i < 5; i++) begin
                exp_r = route(sel[i], internal_status);
                if ((mode == 8'h01 && i < 3) || (mode == 8'h02 && i < 4)) exp_r = alarm_code[i];
                chk(collector_oe[i], exp_r ^ pol[i][0]);
            end
            exp_r = route(sel[5], internal_status) ^ pol[5][0];
            chk(relay_first_closed, exp_r);
            chk(relay_second_closed, !exp_r);
            chk(collector_out, 32'h0);
        end
        wr(8'h15, 32'h0);
        wait_cyc(3);
        chk(relay_first_closed, internal_status[0] ^ pol[5][0]);
        // pulse counting with irq
        pidx = $unsigned($random(seed)) % 8;
        cidx = (pidx + 1) % 8;
        wr(8'(pidx), 32'd74);
        wr(8'(cidx), 32'd75);
        wr(8'h08 + 8'(pidx), 32'd3);
        wr(8'h08 + 8'(cidx), 32'd3);
        wr(8'h21, 32'h7);
        wr(8'h22, 32'h1);
        terminal_driver_inst.pulse(pidx, 5, 40);
        wait_cyc(40);
        rd(8'h20, rv);
        chk(rv, 32'd5);
        chk(pulse_total_monitor, 32'd5);
        chk(irq, 32'h1);
        terminal_driver_inst.pulse(pidx, 10, 4);
        wait_cyc(40);
        chk(pulse_total_monitor, 32'd5);
        wr(8'h22, 32'h0);
        wait_cyc(3);
        chk(irq, 32'h0);
        wr(8'h21, 32'h7);
        wr(8'h22, 32'h1);
        wait_cyc(3);
        chk(irq, 32'h0);
        terminal_driver_inst.set_level(cidx, 1'b1);
        wait_cyc(40);
        chk(pulse_total_monitor, 32'd0);
        rd(8'h23, rv);
        chk(rv, 32'h1 << cidx);
        terminal_driver_inst.pulse(pidx, 3, 40);
        wait_cyc(40);
        chk(pulse_total_monitor, 32'h0);
        rd(8'h21, rv);
        chk(rv, 32'h2);
        terminal_driver_inst.set_level(cidx, 1'b0);
        wait_cyc(40);
        terminal_driver_inst.pulse(pidx, 2, 40);
        wait_cyc(40);
        rd(8'h20, rv);
        chk(rv, 32'd2);
        // reset in mid-run
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        wait_cyc(2);
        rd(8'h20, rv);
        chk(rv, 32'd0);
        chk(pulse_total_monitor, 32'd0);
        rd(8'(pidx), rv);
        chk(rv, 32'hFF);
        complete_run();
    end
endmodule
`default_nettype wire

// >>> verification/terminal_driver.sv
// external controller model: drives the input terminal pins
// assumes the router samples its terminals on core_clk
`timescale 1ns/100ps
`default_nettype none
module terminal_driver
    import mft_pkg::*;
(
    input wire logic core_clk,
    output logic [NUM_INPUTS-1:0] terminal_in
);
    initial terminal_in = '0;

    task automatic set_level(input int idx, input logic v);
        @(posedge core_clk);
        terminal_in[idx] <= v;
    endtask

    // half below one filter window breaks the rate limit on purpose
    task automatic pulse(input int idx, input int n, input int half);
        repeat (n) begin
            set_level(idx, 1'b1);
            repeat (half - 1) @(posedge core_clk);
            set_level(idx, 1'b0);
            repeat (half - 1) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire
